// >>> verilog/msp_regs.sv
// memory size and partition register bank behind an axi4-lite slave
`timescale 1ns/1ps
module msp_regs #(
  parameter logic [31:0] DATA_RAM_BYTES = 32'h0001_0000,
  parameter logic [31:0] PROGRAM_FLASH_BYTES = 32'h0008_0000
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // write address
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // partition to the bus matrix
  output logic [31:0] userProgramBase,
  output logic baseAboveFlash,
  output logic kernelOnly
);
  import msp_pkg::*;

  // elaboration checks on the size configuration
  if (DATA_RAM_BYTES != RAM_16K && DATA_RAM_BYTES != RAM_32K &&
      DATA_RAM_BYTES != RAM_64K) begin : g_bad_ram
    $error("data ram size must be 16, 32 or 64 KB");
  end
  if (PROGRAM_FLASH_BYTES != FLASH_64K && PROGRAM_FLASH_BYTES != FLASH_128K &&
      PROGRAM_FLASH_BYTES != FLASH_256K &&
      PROGRAM_FLASH_BYTES != FLASH_512K) begin : g_bad_flash
    $error("program flash size must be 64, 128, 256 or 512 KB");
  end

  msp_wreq_s wreq;
  msp_rdsrc_s rdSrc;
  logic wrFire;
  logic [31:0] byteMask;
  logic [31:0] next_base;

  // write channels
  msp_axil_write u_write (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .wreq(wreq),
    .wrFire(wrFire)
  );

  // read channels
  msp_axil_read u_read (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .src(rdSrc)
  );

  // byte lanes expanded to a bit mask
  genvar lane;
  for (lane = 0; lane < 4; lane++) begin : g_lane
    assign byteMask[lane*8 +: 8] = {8{wreq.strb[lane]}};
  end

  // only bits 19:11 take new data, the rest stay zero
  assign next_base = (userProgramBase & ~(byteMask & BASE_WR_MASK)) |
                     (wreq.data & byteMask & BASE_WR_MASK);

  // user program base register, zero after reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      userProgramBase <= BASE_RESET;
    end else if (wrFire && msp_decode(wreq.addr) == REG_BASE) begin
      userProgramBase <= next_base;
    end
  end

  // partition status follows the base with one cycle of delay
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      baseAboveFlash <= 1'b0;
      kernelOnly <= 1'b1;
    end else begin
      baseAboveFlash <= userProgramBase > PROGRAM_FLASH_BYTES;
      kernelOnly <= userProgramBase == BASE_RESET;
    end
  end

  // read sources; size registers are constants no write can reach
  always_comb begin
    rdSrc.dataRam = DATA_RAM_BYTES;
    rdSrc.base = userProgramBase;
    rdSrc.pflash = PROGRAM_FLASH_BYTES;
    rdSrc.boot = BOOT_FLASH_BYTES;
    rdSrc.status = 32'h0000_0000;
    rdSrc.status[STAT_ABOVE_FLASH] = baseAboveFlash;
    rdSrc.status[STAT_KERNEL_ONLY] = kernelOnly;
  end

  // helper: high from the first edge after reset release
  logic resetSeen;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resetSeen <= 1'b0;
    end else begin
      resetSeen <= 1'b1;
    end
  end

  // helper: decoded read and write targets
  msp_reg_e arTarget;
  msp_reg_e wrTarget;
  assign arTarget = msp_decode(araddr);
  assign wrTarget = msp_decode(wreq.addr);

  // read of the data ram size returns the configured byte count
  a_ram_size_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    arvalid && arready && arTarget == REG_DATA_RAM |=>
      rvalid && rresp == RESP_OKAY && rdata == DATA_RAM_BYTES)
    else $error("data ram size read returned a wrong value");

  // read of the program flash size returns the configured byte count
  a_flash_size_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    arvalid && arready && arTarget == REG_PFLASH |=>
      rvalid && rdata == PROGRAM_FLASH_BYTES ##1
      (rdata == PROGRAM_FLASH_BYTES || !rvalid))
    else $error("program flash size read returned a wrong value");

  // read of the boot flash size always returns 12 KB
  a_boot_size_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    arvalid && arready && arTarget == REG_BOOT |=>
      rvalid && rdata == 32'h0000_3000)
    else $error("boot flash size read returned a wrong value");

  // a full-strobe write to the base lands in bits 19:11 only
  a_base_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wrFire && wrTarget == REG_BASE && wreq.strb == 4'hf |=>
      userProgramBase == ($past(wreq.data) & 32'h000f_f800) &&
      bvalid && bresp == RESP_OKAY)
    else $error("base write did not store bits 19 to 11");

  // the base then reads back what was stored
  a_base_read_back: assert property (@(posedge clk_sys) disable iff (!rst_n)
    arvalid && arready && arTarget == REG_BASE |=>
      rdata == $past(userProgramBase) && rdata[10:0] == 11'h000)
    else $error("base read back differs or low bits set");

  // bits 31:20 never hold a one
  a_base_high_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    userProgramBase[31:20] == 12'h000 && rdSrc.base[10:0] == 11'h000)
    else $error("unimplemented base bits are not zero");

  // the first cycle after reset shows a zero base and kernel only
  a_reset_base_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !resetSeen |-> userProgramBase == 32'h0000_0000 && kernelOnly)
    else $error("base not zero after reset");

  // a write to a size register leaves everything as it was
  a_ro_write_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wrFire && (wrTarget == REG_DATA_RAM || wrTarget == REG_PFLASH ||
               wrTarget == REG_BOOT) |=>
      $stable(userProgramBase) && bvalid && bresp == RESP_OKAY ##1
      rdSrc.dataRam == DATA_RAM_BYTES && rdSrc.boot == 32'h0000_3000)
    else $error("write to a read-only size register had an effect");

  // the status flag tracks a base beyond the flash size
  a_above_flash_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    resetSeen |=> baseAboveFlash ==
      ($past(userProgramBase) > PROGRAM_FLASH_BYTES))
    else $error("above-flash flag does not follow the base");

  // unmapped read addresses answer with an error and zero data
  a_unmapped_error: assert property (@(posedge clk_sys) disable iff (!rst_n)
    arvalid && arready && arTarget == REG_NONE |=>
      rvalid && rresp == RESP_SLVERR && rdata == 32'h0000_0000)
    else $error("unmapped read did not answer with an error");

  // scenarios worth seeing
  c_base_written: cover property (@(posedge clk_sys) disable iff (!rst_n)
    wrFire && wrTarget == REG_BASE ##1 userProgramBase != 32'h0000_0000);
  c_ro_written: cover property (@(posedge clk_sys) disable iff (!rst_n)
    wrFire && wrTarget == REG_PFLASH);
  c_base_over_flash: cover property (@(posedge clk_sys) disable iff (!rst_n)
    baseAboveFlash);
  c_unmapped_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
    rvalid && rresp == RESP_SLVERR);

endmodule // msp_regs

// >>> verilog/msp_pkg.sv
// package: register map, field layout and carriers for write requests and read values
package msp_pkg;

  // register byte offsets
  localparam logic [31:0] OFS_DATA_RAM_SIZE = 32'h0000_0000;
  localparam logic [31:0] OFS_USER_PROGRAM_BASE = 32'h0000_0004;
  localparam logic [31:0] OFS_PROGRAM_FLASH_SIZE = 32'h0000_0008;
  localparam logic [31:0] OFS_BOOT_FLASH_SIZE = 32'h0000_000c;
  localparam logic [31:0] OFS_PARTITION_STATUS = 32'h0000_0010;

  // size encodings in bytes
  localparam logic [31:0] RAM_16K = 32'h0000_4000;
  localparam logic [31:0] RAM_32K = 32'h0000_8000;
  localparam logic [31:0] RAM_64K = 32'h0001_0000;
  localparam logic [31:0] FLASH_64K = 32'h0001_0000;
  localparam logic [31:0] FLASH_128K = 32'h0002_0000;
  localparam logic [31:0] FLASH_256K = 32'h0004_0000;
  localparam logic [31:0] FLASH_512K = 32'h0008_0000;
  localparam logic [31:0] BOOT_FLASH_BYTES = 32'h0000_3000;

  // user program base field layout
  localparam logic [31:0] BASE_WR_MASK = 32'h000f_f800;
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;
  localparam int BASE_LSB = 11;
  localparam int BASE_MSB = 19;

  // partition status bit positions
  localparam int STAT_ABOVE_FLASH = 0;
  localparam int STAT_KERNEL_ONLY = 1;

  // bus response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    REG_DATA_RAM, REG_BASE, REG_PFLASH, REG_BOOT, REG_STATUS, REG_NONE
  } msp_reg_e;

  // a joined write request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } msp_wreq_s;

  // values offered to the read path
  typedef struct packed {
    logic [31:0] dataRam;
    logic [31:0] base;
    logic [31:0] pflash;
    logic [31:0] boot;
    logic [31:0] status;
  } msp_rdsrc_s;

  // address decode shared by both channels and the checks
  function automatic msp_reg_e msp_decode(input logic [31:0] addr);
    logic [31:0] word;
    word = {addr[31:2], 2'h0};
    if (word == OFS_DATA_RAM_SIZE) begin
      return REG_DATA_RAM;
    end else if (word == OFS_USER_PROGRAM_BASE) begin
      return REG_BASE;
    end else if (word == OFS_PROGRAM_FLASH_SIZE) begin
      return REG_PFLASH;
    end else if (word == OFS_BOOT_FLASH_SIZE) begin
      return REG_BOOT;
    end else if (word == OFS_PARTITION_STATUS) begin
      return REG_STATUS;
    end else begin
      return REG_NONE;
    end
  endfunction

endpackage

// >>> verilog/msp_axil_write.sv
// write channels: joins address and data in either order, answers on b
`timescale 1ns/1ps
module msp_axil_write (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // write address
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // joined request to the register file
  output msp_pkg::msp_wreq_s wreq,
  output logic wrFire
);
  import msp_pkg::*;

  logic awHeld;
  logic wHeld;
  logic [31:0] heldAddr;
  logic [31:0] heldData;
  logic [3:0] heldStrb;

  // one driver per captured field, joined here for the register file
  assign wreq = '{addr: heldAddr, data: heldData, strb: heldStrb};

  // both halves present and no answer outstanding
  assign wrFire = awHeld && wHeld && !bvalid;

  // address capture
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      awready <= 1'b0;
      heldAddr <= 32'h0000_0000;
    end else if (awvalid && awready) begin
      awHeld <= 1'b1;
      awready <= 1'b0;
      heldAddr <= awaddr;
    end else if (wrFire) begin
      awHeld <= 1'b0;
    end else if (!awHeld && !bvalid) begin
      awready <= 1'b1;
    end
  end

  // data capture
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wHeld <= 1'b0;
      wready <= 1'b0;
      heldData <= 32'h0000_0000;
      heldStrb <= 4'h0;
    end else if (wvalid && wready) begin
      wHeld <= 1'b1;
      wready <= 1'b0;
      heldData <= wdata;
      heldStrb <= wstrb;
    end else if (wrFire) begin
      wHeld <= 1'b0;
    end else if (!wHeld && !bvalid) begin
      wready <= 1'b1;
    end
  end

  // response, unmapped addresses answer with an error
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wrFire) begin
      bvalid <= 1'b1;
      bresp <= (msp_decode(wreq.addr) == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

endmodule // msp_axil_write

// >>> verilog/msp_axil_read.sv
// read channels: takes one address, answers with registered data
`timescale 1ns/1ps
module msp_axil_read (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // read address
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register values
  input wire msp_pkg::msp_rdsrc_s src
);
  import msp_pkg::*;

  // data are sampled at the edge that takes the address
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      case (msp_decode(araddr))
        REG_DATA_RAM: rdata <= src.dataRam;
        REG_BASE: rdata <= src.base;
        REG_PFLASH: rdata <= src.pflash;
        REG_BOOT: rdata <= src.boot;
        REG_STATUS: rdata <= src.status;
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

endmodule // msp_axil_read

// >>> sim/tb.sv
// self-checking bench for the memory size and partition register bank
`timescale 1ns/1ps
module tb;
  import msp_pkg::*;

  localparam logic [31:0] RAM_BYTES = 32'h0000_8000;
  localparam logic [31:0] PF_BYTES = 32'h0002_0000;

  logic clk_sys, rst_n;
  logic [31:0] awaddr, wdata, araddr, rdata, userProgramBase;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, baseAboveFlash, kernelOnly;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int n_mismatch = 0;
  int compares = 0;
  int seed, k;
  logic [31:0] base, d;
  logic [1:0] r;
  logic [3:0] s;
  logic [31:0] corner [8] = '{32'hffff_ffff, 32'h0000_0000, 32'h0000_0800,
    32'h000f_f800, 32'h0002_0000, 32'h0002_0800, 32'h0000_07ff,
    32'hfff0_0000};
  logic [31:0] roAddr [4] = '{32'h0, 32'h8, 32'hc, 32'h10};
  logic [31:0] badAddr [2] = '{32'h14, 32'h100};

  msp_regs #(
    .DATA_RAM_BYTES(RAM_BYTES),
    .PROGRAM_FLASH_BYTES(PF_BYTES)
  ) msp_regs_i (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .userProgramBase(userProgramBase), .baseAboveFlash(baseAboveFlash),
    .kernelOnly(kernelOnly)
  );

  // 200 MHz system clock
  initial clk_sys = 1'b0;
  always #2.5 clk_sys = ~clk_sys;

  // compare one value and count it
  task automatic check(input logic [33:0] seen, exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // print the counts and the verdict, then stop
  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // expected base value after a write with byte strobes
  function automatic logic [31:0] next_base(input logic [31:0] old,
      input logic [31:0] dat, input logic [3:0] stb);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (stb[i]) begin
        v[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return v & 32'h000f_f800;
  endfunction

  // one write: address and data offered together, each released when taken
  task automatic axi_write(input logic [31:0] a, dat, input logic [3:0] stb,
      output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= dat;
    wstrb <= stb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 200);
    if (bvalid !== 1'b1) begin
      n_mismatch++;
      $display("BAD t=%0t write answer never came", $time);
    end
    resp = bresp;
    bready <= 1'b0;
  endtask

  // one read: address held until taken, data taken with rvalid
  task automatic axi_read(input logic [31:0] a, output logic [31:0] dat,
      output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 200);
    if (rvalid !== 1'b1) begin
      n_mismatch++;
      $display("BAD t=%0t read answer never came", $time);
    end
    dat = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // read every register and compare with the expected base
  task automatic check_all(input logic [31:0] b);
    logic [31:0] v;
    logic [1:0] rs;
    axi_read(32'h0, v, rs);
    check({rs, v}, {RESP_OKAY, RAM_BYTES}, "ram size");
    axi_read(32'h4, v, rs);
    check({rs, v}, {RESP_OKAY, b}, "base");
    axi_read(32'h8, v, rs);
    check({rs, v}, {RESP_OKAY, PF_BYTES}, "flash size");
    axi_read(32'hc, v, rs);
    check({rs, v}, {RESP_OKAY, 32'h0000_3000}, "boot size");
    axi_read(32'h10, v, rs);
    check({rs, v}, {RESP_OKAY, 30'h0, b == 0, b > PF_BYTES}, "status");
    check({2'h0, userProgramBase}, {2'h0, b}, "base port");
    check({32'h0, kernelOnly, baseAboveFlash},
      {32'h0, b == 0, b > PF_BYTES}, "partition flags");
  endtask

  // watchdog against a hung handshake
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop;
  end

  // main sequence
  initial begin
    seed = $urandom(79);
    rst_n = 1'b0;
    awaddr = 32'h0;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 32'h0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    base = 32'h0;
    check_all(base);
    // corner values first, then random data and strobes
    for (k = 0; k < 28; k++) begin
      d = (k < 8) ? corner[k] : $urandom;
      s = (k < 8) ? 4'hf : 4'($urandom);
      axi_write(OFS_USER_PROGRAM_BASE, d, s, r);
      check({r, 32'h0}, {RESP_OKAY, 32'h0}, "base write resp");
      base = next_base(base, d, s);
      check_all(base);
    end
    // writes to the read-only places are accepted and ignored
    for (k = 0; k < 4; k++) begin
      axi_write(roAddr[k], $urandom, 4'hf, r);
      check({r, 32'h0}, {RESP_OKAY, 32'h0}, "ro write resp");
      check_all(base);
    end
    // unmapped words answer with an error and change nothing
    for (k = 0; k < 2; k++) begin
      axi_write(badAddr[k], $urandom, 4'hf, r);
      check({r, 32'h0}, {RESP_SLVERR, 32'h0}, "bad write resp");
      axi_read(badAddr[k], d, r);
      check({r, d}, {RESP_SLVERR, 32'h0}, "bad read");
      check_all(base);
    end
    // low address bits are ignored by the decode
    axi_read(32'h6, d, r);
    check({r, d}, {RESP_OKAY, base}, "unaligned read");
    // reset in mid-run clears the base but not the sizes
    axi_write(OFS_USER_PROGRAM_BASE, 32'h000f_f800, 4'hf, r);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check({1'b0, kernelOnly, userProgramBase}, {2'h1, 32'h0}, "in reset");
    rst_n <= 1'b1;
    base = 32'h0;
    check_all(base);
    report_and_stop;
  end

endmodule // tb
